/* File: seq_consts.svh */
/*
 * bus status codes, workspace register numbers and cycle counts
 * for the bus cycle sequencer.
 * assumes it is included by its bare name, ahead of the design file.
 */
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

// ==========================================================
// bus status codes
`define BST_ALU 4'h9
`define BST_WS 4'h6
`define BST_FETCH 4'h3
`define BST_SRC 4'h1
`define BST_IMM 4'h2
`define BST_STOUT 4'hd
`define BST_WPOUT 4'hc

// ==========================================================
// workspace register numbers used by the return and by the shift count read
`define WR_PC 4'he
`define WR_STAT 4'hf
`define WR_WP 4'hd
`define WR_COUNT 4'h0

// ==========================================================
// fixed internal cycle run lengths
`define MPY_ALU_N 19
`define RET_ALU_N 2
`define MACRO_ALU_N 5
`define SHIFT_PRE_N 2

`endif

/* File: seq_pkg.sv */
/*
 * types for the bus cycle sequencer: instruction class and states.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package seq_pkg;

   // ==========================================================
   // instruction classes handled here
   typedef enum logic [1:0] {
      op_signed_multiply,
      op_ret,
      op_ret_macro,
      op_shift
   } op_t;

   // ==========================================================
   // sequencer states, one bus cycle each unless counted
   typedef enum logic [5:0] {
      st_idle,
      st_m_src, st_m_int, st_m_dst, st_m_alu, st_m_wmsw, st_m_fetch,
      st_m_wlsw,
      st_r_int, st_r_pc, st_r_st, st_r_wp, st_r_alu, st_r_stout,
      st_r_fetch, st_r_wpout,
      st_x_alu, st_x_fetch, st_x_end,
      st_s_iop, st_s_int, st_s_msw, st_s_alua, st_s_lsw, st_s_alub,
      st_s_shift, st_s_wlsw, st_s_fetch, st_s_wmsw,
      st_l_int, st_l_wr0, st_l_alu, st_l_lsw, st_l_pre, st_l_post
   } state_t;

endpackage

/* File: instr_bus_cycle_sequencer.sv */
/*
 * bus cycle sequencer for signed multiply, return with workspace
 * (main memory and macrostore forms) and multi-word arithmetic shifts.
 * assumes one bus cycle per clock and that external logic decodes the
 * 4-bit status, read and write outputs; the count read from workspace
 * register 0 arrives on count_reg_in during that read cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "seq_consts.svh"

// Operation
// - multiply: source, internal, destination workspace read
// - multiply runs nineteen internal cycles
// - write upper word, fetch, write lower word
// - return: internal, read registers 14, 15, 13
// - two internal, status out, fetch, pointer out
// - macrostore return: five internal, fetch, internal
// - shift: immediate fetch, internal, upper source read
// - nonzero count: two internal, lower read, two internal, shifts
// - immediate path writes lower, fetches, writes upper
// - zero count: internal, read count register 0
// - register path: two internal, lower read, internal
// - register count: internal, then shifts if nonzero
// - register path ends lower write, fetch, upper write
// - workspace operand uses workspace status code
// - shift cycles equal effective count
module instr_bus_cycle_sequencer #(
   parameter int CNT_W = 4
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // instruction request
   input wire logic start_in,
   input wire seq_pkg::op_t op_in,
   input wire logic [CNT_W-1:0] count_in,
   input wire logic [3:0] dst_reg_in,
   input wire logic [3:0] src_reg_in,
   input wire logic src_in_ws_in,
   // count read back from workspace register 0
   input wire logic [CNT_W-1:0] count_reg_in,
   // bus cycle outputs
   output logic [3:0] status_out,
   output logic read_out,
   output logic write_out,
   output logic [3:0] reg_index_out,
   output logic busy_out,
   output logic done_out
);

   localparam int REP_W = (CNT_W > 5) ? CNT_W : 5;

   // ==========================================================
   // parameter check
   if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
      $error("CNT_W must lie between 1 and 16");
   end

   seq_pkg::state_t state_q, state_d;
   logic [REP_W-1:0] rep_q, rep_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [3:0] dst_q, dst_d, src_q, src_d;
   logic ws_q, ws_d, last;
   logic [3:0] status_d, idx_d;
   logic rd_d, wr_d, done_d, busy_d;

   // ==========================================================
   // next state and run counter
   always_comb begin
      state_d = state_q;
      rep_d = rep_q;
      cnt_d = cnt_q;
      dst_d = dst_q;
      src_d = src_q;
      ws_d = ws_q;
      done_d = 1'b0;
      last = (rep_q <= REP_W'(1));
      case (state_q)
         seq_pkg::st_idle: begin
            if (start_in) begin
               dst_d = dst_reg_in;
               src_d = src_reg_in;
               ws_d = src_in_ws_in;
               cnt_d = count_in;
               case (op_in)
                  seq_pkg::op_signed_multiply: state_d = seq_pkg::st_m_src;
                  seq_pkg::op_ret: state_d = seq_pkg::st_r_int;
                  seq_pkg::op_ret_macro: begin
                     state_d = seq_pkg::st_x_alu;
                     rep_d = REP_W'(`MACRO_ALU_N);
                  end
                  default: state_d = seq_pkg::st_s_iop;
               endcase
            end
         end
         // signed multiply
         seq_pkg::st_m_src: state_d = seq_pkg::st_m_int;
         seq_pkg::st_m_int: state_d = seq_pkg::st_m_dst;
         seq_pkg::st_m_dst: begin
            state_d = seq_pkg::st_m_alu;
            rep_d = REP_W'(`MPY_ALU_N);
         end
         seq_pkg::st_m_alu: begin
            if (last) state_d = seq_pkg::st_m_wmsw;
            else rep_d = rep_q - REP_W'(1);
         end
         seq_pkg::st_m_wmsw: state_d = seq_pkg::st_m_fetch;
         seq_pkg::st_m_fetch: state_d = seq_pkg::st_m_wlsw;
         // return from main memory
         seq_pkg::st_r_int: state_d = seq_pkg::st_r_pc;
         seq_pkg::st_r_pc: state_d = seq_pkg::st_r_st;
         seq_pkg::st_r_st: state_d = seq_pkg::st_r_wp;
         seq_pkg::st_r_wp: begin
            state_d = seq_pkg::st_r_alu;
            rep_d = REP_W'(`RET_ALU_N);
         end
         seq_pkg::st_r_alu: begin
            if (last) state_d = seq_pkg::st_r_stout;
            else rep_d = rep_q - REP_W'(1);
         end
         seq_pkg::st_r_stout: state_d = seq_pkg::st_r_fetch;
         seq_pkg::st_r_fetch: state_d = seq_pkg::st_r_wpout;
         // return from macrostore
         seq_pkg::st_x_alu: begin
            if (last) state_d = seq_pkg::st_x_fetch;
            else rep_d = rep_q - REP_W'(1);
         end
         seq_pkg::st_x_fetch: state_d = seq_pkg::st_x_end;
         // multi-word shift, immediate count
         seq_pkg::st_s_iop: state_d = seq_pkg::st_s_int;
         seq_pkg::st_s_int: state_d = seq_pkg::st_s_msw;
         seq_pkg::st_s_msw: begin
            if (cnt_q != '0) begin
               state_d = seq_pkg::st_s_alua;
               rep_d = REP_W'(`SHIFT_PRE_N);
            end else begin
               state_d = seq_pkg::st_l_int;
            end
         end
         seq_pkg::st_s_alua: begin
            if (last) state_d = seq_pkg::st_s_lsw;
            else rep_d = rep_q - REP_W'(1);
         end
         seq_pkg::st_s_lsw: begin
            state_d = seq_pkg::st_s_alub;
            rep_d = REP_W'(`SHIFT_PRE_N);
         end
         seq_pkg::st_s_alub: begin
            if (last) begin
               state_d = seq_pkg::st_s_shift;
               rep_d = REP_W'(cnt_q);
            end else begin
               rep_d = rep_q - REP_W'(1);
            end
         end
         seq_pkg::st_s_shift: begin
            if (last) state_d = seq_pkg::st_s_wlsw;
            else rep_d = rep_q - REP_W'(1);
         end
         seq_pkg::st_s_wlsw: state_d = seq_pkg::st_s_fetch;
         seq_pkg::st_s_fetch: state_d = seq_pkg::st_s_wmsw;
         // multi-word shift, count from register 0
         seq_pkg::st_l_int: state_d = seq_pkg::st_l_wr0;
         seq_pkg::st_l_wr0: begin
            cnt_d = count_reg_in;
            state_d = seq_pkg::st_l_alu;
            rep_d = REP_W'(`SHIFT_PRE_N);
         end
         seq_pkg::st_l_alu: begin
            if (last) state_d = seq_pkg::st_l_lsw;
            else rep_d = rep_q - REP_W'(1);
         end
         seq_pkg::st_l_lsw: state_d = seq_pkg::st_l_pre;
         seq_pkg::st_l_pre: state_d = seq_pkg::st_l_post;
         seq_pkg::st_l_post: begin
            if (cnt_q != '0) begin
               state_d = seq_pkg::st_s_shift;
               rep_d = REP_W'(cnt_q);
            end else begin
               state_d = seq_pkg::st_s_wlsw;
            end
         end
         default: begin
            state_d = seq_pkg::st_idle;
            done_d = 1'b1;
         end
      endcase
   end

   // ==========================================================
   // bus cycle outputs decoded from the coming state
   always_comb begin
      status_d = `BST_ALU;
      rd_d = 1'b0;
      wr_d = 1'b0;
      idx_d = 4'h0;
      busy_d = (state_d != seq_pkg::st_idle);
      case (state_d)
         seq_pkg::st_m_src, seq_pkg::st_s_msw, seq_pkg::st_s_lsw,
         seq_pkg::st_l_lsw: begin
            status_d = ws_d ? `BST_WS : `BST_SRC;
            rd_d = 1'b1;
            idx_d = src_d;
         end
         seq_pkg::st_s_wlsw, seq_pkg::st_s_wmsw: begin
            status_d = ws_d ? `BST_WS : `BST_SRC;
            wr_d = 1'b1;
            idx_d = src_d;
         end
         seq_pkg::st_m_dst: begin
            status_d = `BST_WS;
            rd_d = 1'b1;
            idx_d = dst_d;
         end
         seq_pkg::st_m_wmsw: begin
            status_d = `BST_WS;
            wr_d = 1'b1;
            idx_d = dst_d;
         end
         seq_pkg::st_m_wlsw: begin
            status_d = `BST_WS;
            wr_d = 1'b1;
            idx_d = dst_d + 4'h1;
         end
         seq_pkg::st_r_pc, seq_pkg::st_r_st, seq_pkg::st_r_wp,
         seq_pkg::st_l_wr0: begin
            status_d = `BST_WS;
            rd_d = 1'b1;
            idx_d = (state_d == seq_pkg::st_r_pc) ? `WR_PC :
                    (state_d == seq_pkg::st_r_st) ? `WR_STAT :
                    (state_d == seq_pkg::st_r_wp) ? `WR_WP : `WR_COUNT;
         end
         seq_pkg::st_m_fetch, seq_pkg::st_r_fetch, seq_pkg::st_x_fetch,
         seq_pkg::st_s_fetch: begin
            status_d = `BST_FETCH;
            rd_d = 1'b1;
         end
         seq_pkg::st_s_iop: begin
            status_d = `BST_IMM;
            rd_d = 1'b1;
         end
         seq_pkg::st_r_stout: status_d = `BST_STOUT;
         seq_pkg::st_r_wpout: status_d = `BST_WPOUT;
         default: status_d = `BST_ALU;
      endcase
   end

   // ==========================================================
   // state and output registers, one bus cycle per clock
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= seq_pkg::st_idle;
         rep_q <= '0;
         cnt_q <= '0;
         dst_q <= 4'h0;
         src_q <= 4'h0;
         ws_q <= 1'b0;
         status_out <= `BST_ALU;
         read_out <= 1'b0;
         write_out <= 1'b0;
         reg_index_out <= 4'h0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         state_q <= state_d;
         rep_q <= rep_d;
         cnt_q <= cnt_d;
         dst_q <= dst_d;
         src_q <= src_d;
         ws_q <= ws_d;
         status_out <= status_d;
         read_out <= rd_d;
         write_out <= wr_d;
         reg_index_out <= idx_d;
         busy_out <= busy_d;
         done_out <= done_d;
      end
   end

   // ==========================================================
   // checks: helper counters
   logic [4:0] mpy_n_q;
   logic [REP_W-1:0] shift_n_q;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mpy_n_q <= 5'h00;
         shift_n_q <= '0;
      end else begin
         mpy_n_q <= (state_q == seq_pkg::st_m_alu) ? mpy_n_q + 5'h01 :
                    (state_q == seq_pkg::st_idle) ? 5'h00 : mpy_n_q;
         shift_n_q <= (state_q == seq_pkg::st_s_shift) ?
                      shift_n_q + REP_W'(1) :
                      (state_q == seq_pkg::st_idle) ? '0 : shift_n_q;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   property p_mpy_dst;
      state_q == seq_pkg::st_m_int |-> status_out == `BST_ALU ##1
         (status_out == `BST_WS && read_out && reg_index_out == dst_q);
   endproperty
   a_mpy_dst: assert property (p_mpy_dst) else $error("mpy dst read");
   property p_mpy_alu;
      state_q == seq_pkg::st_m_wmsw |-> mpy_n_q == 5'h13;
   endproperty
   a_mpy_alu: assert property (p_mpy_alu) else $error("mpy alu count");
   property p_mpy_tail;
      state_q == seq_pkg::st_m_wmsw |-> write_out ##1
         status_out == `BST_FETCH ##1
         (write_out && reg_index_out == dst_q + 4'h1 ##1 done_out);
   endproperty
   a_mpy_tail: assert property (p_mpy_tail) else $error("mpy tail");
   property p_ret_reads;
      state_q == seq_pkg::st_r_int |=> reg_index_out == `WR_PC ##1
         reg_index_out == `WR_STAT ##1 reg_index_out == `WR_WP;
   endproperty
   a_ret_reads: assert property (p_ret_reads) else $error("ret reads");
   property p_ret_tail;
      state_q == seq_pkg::st_r_wp |=> (status_out == `BST_ALU)[*2] ##1
         status_out == `BST_STOUT ##1 status_out == `BST_FETCH ##1
         status_out == `BST_WPOUT;
   endproperty
   a_ret_tail: assert property (p_ret_tail) else $error("ret tail");
   property p_macro;
      start_in && !busy_out && op_in == seq_pkg::op_ret_macro |=>
         (status_out == `BST_ALU && !read_out)[*5] ##1
         status_out == `BST_FETCH ##1 status_out == `BST_ALU ##1 done_out;
   endproperty
   a_macro: assert property (p_macro) else $error("macro return");
   property p_shift_head;
      start_in && !busy_out && op_in == seq_pkg::op_shift |=>
         status_out == `BST_IMM ##1 status_out == `BST_ALU ##1 read_out;
   endproperty
   a_shift_head: assert property (p_shift_head) else $error("shift head");
   property p_ws_subst;
      (read_out || write_out) && status_out != `BST_FETCH &&
      status_out != `BST_IMM && reg_index_out == src_q && ws_q &&
      busy_out |-> status_out != `BST_SRC;
   endproperty
   a_ws_subst: assert property (p_ws_subst) else $error("ws substitute");
   property p_shift_cnt;
      state_q == seq_pkg::st_s_wlsw |-> shift_n_q == REP_W'(cnt_q);
   endproperty
   a_shift_cnt: assert property (p_shift_cnt) else $error("shift count");
   property p_count_rd;
      state_q == seq_pkg::st_l_int |=> status_out == `BST_WS && read_out &&
         reg_index_out == `WR_COUNT;
   endproperty
   a_count_rd: assert property (p_count_rd) else $error("count read");

   c_mpy: cover property (state_q == seq_pkg::st_m_wlsw);
   c_ret: cover property (state_q == seq_pkg::st_r_wpout);
   c_zero_reg: cover property (state_q == seq_pkg::st_l_post &&
      cnt_q == '0);

endmodule
`default_nettype wire

/* File: bus_status_partner.sv */
/*
 * model of the memory and status decoding logic beyond the sequencer.
 * assumes the sequencer's registered outputs are settled mid-cycle and
 * that the bench supplies the word held in workspace register 0.
 */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// workspace register 0 read answer
module bus_status_partner (
   // bus cycle as decoded from the sequencer
   input wire logic [3:0] status_in,
   input wire logic read_in,
   input wire logic busy_in,
   input wire logic [3:0] reg_index_in,
   // word stored in register 0
   input wire logic [3:0] count_val_in,
   // read data back to the sequencer
   output logic [3:0] count_reg_out
);
   logic reg0_read;

   // decode a workspace read of register 0
   assign reg0_read = busy_in && read_in && status_in == 4'h6 &&
                      reg_index_in == 4'h0;

   // bus not driven with the word: show its inverse so stale data fails
   assign count_reg_out = reg0_read ? count_val_in : ~count_val_in;
endmodule
`default_nettype wire

/* File: tb_top.sv */
/*
 * self-checking bench for the bus cycle sequencer: corner cases then
 * random instructions, each bus cycle compared against a built list.
 * assumes the design files and the partner model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "seq_consts.svh"

module tb_top;
   // ==========================================================
   // signals
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic start_in = 1'b0;
   seq_pkg::op_t op_in = seq_pkg::op_signed_multiply;
   logic [3:0] count_in = 4'h0;
   logic [3:0] dst_reg_in = 4'h0;
   logic [3:0] src_reg_in = 4'h0;
   logic src_in_ws_in = 1'b0;
   logic [3:0] count_reg_in;
   logic [3:0] c_val = 4'h0;
   logic [3:0] status_out;
   logic read_out, write_out, busy_out, done_out;
   logic [3:0] reg_index_out;
   logic [9:0] exp_q[$];
   logic [31:0] seed = 32'h04cd1738;
   int n_mismatch = 0;
   int checks = 0;

   // ==========================================================
   // clock, design and far side
   always #2.5 clk_in = ~clk_in;

   instr_bus_cycle_sequencer #(.CNT_W(4)) u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .start_in(start_in),
      .op_in(op_in), .count_in(count_in), .dst_reg_in(dst_reg_in),
      .src_reg_in(src_reg_in), .src_in_ws_in(src_in_ws_in),
      .count_reg_in(count_reg_in), .status_out(status_out),
      .read_out(read_out), .write_out(write_out),
      .reg_index_out(reg_index_out), .busy_out(busy_out),
      .done_out(done_out));

   bus_status_partner u_far (
      .status_in(status_out), .read_in(read_out), .busy_in(busy_out),
      .reg_index_in(reg_index_out), .count_val_in(c_val),
      .count_reg_out(count_reg_in));

   // ==========================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic end_sim;
      if (n_mismatch == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [9:0] e,
                      input logic [9:0] s);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h seen %h", name, e, s);
      end
   endtask

   // push n cycles of {status, read, write, index}
   task automatic add(input logic [3:0] st, input int rd,
                      input int wr, input int idx, input int n);
      logic [31:0] r, w, x;
      r = rd;
      w = wr;
      x = idx;
      for (int i = 0; i < n; i++)
         exp_q.push_back({st, r[0], w[0], x[3:0]});
   endtask

   // expected bus cycle list for one instruction
   task automatic build(input seq_pkg::op_t op, input logic [3:0] cnt,
                        input logic [3:0] dst, input logic [3:0] src,
                        input logic ws, input logic [3:0] c);
      logic [3:0] s;
      s = ws ? `BST_WS : `BST_SRC;
      exp_q.delete();
      case (op)
         seq_pkg::op_signed_multiply: begin
            add(s, 1, 0, src, 1);
            add(`BST_ALU, 0, 0, 0, 1);
            add(`BST_WS, 1, 0, dst, 1);
            add(`BST_ALU, 0, 0, 0, 19);
            add(`BST_WS, 0, 1, dst, 1);
            add(`BST_FETCH, 1, 0, 0, 1);
            add(`BST_WS, 0, 1, dst + 4'h1, 1);
         end
         seq_pkg::op_ret: begin
            add(`BST_ALU, 0, 0, 0, 1);
            add(`BST_WS, 1, 0, 4'he, 1);
            add(`BST_WS, 1, 0, 4'hf, 1);
            add(`BST_WS, 1, 0, 4'hd, 1);
            add(`BST_ALU, 0, 0, 0, 2);
            add(`BST_STOUT, 0, 0, 0, 1);
            add(`BST_FETCH, 1, 0, 0, 1);
            add(`BST_WPOUT, 0, 0, 0, 1);
         end
         seq_pkg::op_ret_macro: begin
            add(`BST_ALU, 0, 0, 0, 5);
            add(`BST_FETCH, 1, 0, 0, 1);
            add(`BST_ALU, 0, 0, 0, 1);
         end
         default: begin
            add(`BST_IMM, 1, 0, 0, 1);
            add(`BST_ALU, 0, 0, 0, 1);
            add(s, 1, 0, src, 1);
            if (cnt != 4'h0) begin
               add(`BST_ALU, 0, 0, 0, 2);
               add(s, 1, 0, src, 1);
               add(`BST_ALU, 0, 0, 0, 2 + cnt);
            end else begin
               add(`BST_ALU, 0, 0, 0, 1);
               add(`BST_WS, 1, 0, 4'h0, 1);
               add(`BST_ALU, 0, 0, 0, 2);
               add(s, 1, 0, src, 1);
               add(`BST_ALU, 0, 0, 0, 2 + c);
            end
            add(s, 0, 1, src, 1);
            add(`BST_FETCH, 1, 0, 0, 1);
            add(s, 0, 1, src, 1);
         end
      endcase
   endtask

   // start one instruction (called just after an edge) and follow it
   task automatic run_one(input seq_pkg::op_t op, input logic [3:0] cnt,
                          input logic [3:0] dst, input logic [3:0] src,
                          input logic ws, input logic [3:0] c);
      build(op, cnt, dst, src, ws, c);
      op_in = op;
      count_in = cnt;
      dst_reg_in = dst;
      src_reg_in = src;
      src_in_ws_in = ws;
      c_val = c;
      start_in = 1'b1;
      @(posedge clk_in);
      #1;
      // start held high through cycle 1: must be ignored while busy
      foreach (exp_q[i]) begin
         chk("bus_cycle", exp_q[i],
             {status_out, read_out, write_out, reg_index_out});
         chk("busy", 10'h1, {9'h0, busy_out});
         @(posedge clk_in);
         #1;
         // drop start once, so the next call raises it in another step
         if (i == 0) start_in = 1'b0;
      end
      chk("done_idle", 10'h1, {8'h0, busy_out, done_out});
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk_in);
      #1;
      rst_in = 1'b0;
      chk("idle", {`BST_ALU, 6'h0},
          {status_out, read_out, write_out, reg_index_out});
      // corner cases, back to back
      run_one(seq_pkg::op_signed_multiply, 4'h0, 4'hf, 4'h3, 1'b1, 4'h0);
      run_one(seq_pkg::op_signed_multiply, 4'h0, 4'h2, 4'h7, 1'b0, 4'h0);
      run_one(seq_pkg::op_ret, 4'h0, 4'h0, 4'h0, 1'b0, 4'h0);
      run_one(seq_pkg::op_ret_macro, 4'h0, 4'h0, 4'h0, 1'b0, 4'h0);
      run_one(seq_pkg::op_shift, 4'h1, 4'h0, 4'h5, 1'b0, 4'h0);
      run_one(seq_pkg::op_shift, 4'hf, 4'h0, 4'h5, 1'b1, 4'h0);
      run_one(seq_pkg::op_shift, 4'h0, 4'h0, 4'h9, 1'b0, 4'h0);
      run_one(seq_pkg::op_shift, 4'h0, 4'h0, 4'h9, 1'b1, 4'hf);
      run_one(seq_pkg::op_shift, 4'h0, 4'h0, 4'h1, 1'b0, 4'h1);
      // random instructions
      for (int k = 0; k < 60; k++) begin
         seed = lfsr(lfsr(lfsr(seed)));
         run_one(seq_pkg::op_t'(seed[1:0]), seed[5:2], seed[9:6],
                 seed[13:10], seed[14], seed[19:16]);
         if (seed[20]) begin
            @(posedge clk_in);
            #1;
         end
      end
      end_sim();
   end
endmodule
`default_nettype wire
